// ---- shared/dic_pkg.sv ----
// dic_pkg: constants, register map and types of the digital input conditioner
// assumes one 50 MHz clock and a classic wishbone register port of 32 bits
// Operation
// [RL1] a new input state is reported only after stability for the full filter time
// [RL2] each input has its own filter time in ms, fifty ms after reset
// [RL3] filter times count in ms, using a ms time base from the clock
// [RL4] an inverted input reports 1 while inactive, 0 while active
// [RL5] inversion is chosen per input, independently of the others
// [RL6] indicator outputs follow the filtered level and ignore inversion
// [RL7] baud rates 600 to 115200 in eleven steps, 19200 after reset
// [RL8] parity none, odd, even, mark or space, even after reset
// [RL9] one or two stop bits, one after reset
// [RL10] packet-end idle gap of 8 to 256 bit times, 8 after reset
// [RL11] station address 1 to 256, 1 after reset
// [RL12] any input change before the filter time expires restarts its timer
package dic_pkg;
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned TICK_MS  = 1;
  localparam int unsigned TICK_CYC = TICK_MS * CLK_HZ / 1000;
  localparam int unsigned N_IN     = 16;

  typedef logic [15:0] dic_ms_t;
  typedef logic [16:0] dic_bitcyc_t;

  typedef enum logic [2:0] {
    PAR_NONE  = 3'b000,
    PAR_ODD   = 3'b001,
    PAR_EVEN  = 3'b010,
    PAR_MARK  = 3'b011,
    PAR_SPACE = 3'b100
  } dic_parity_t;

  typedef struct packed {
    logic [3:0]  baud_sel;
    dic_bitcyc_t bit_cyc;
    dic_parity_t parity;
    logic        stop2;
    logic [7:0]  gap_m1;
    logic [7:0]  station_m1;
  } dic_link_cfg_t;

  // register byte addresses
  localparam logic [7:0] ADR_STATE   = 8'h00;
  localparam logic [7:0] ADR_LEVEL   = 8'h04;
  localparam logic [7:0] ADR_INVERT  = 8'h08;
  localparam logic [7:0] ADR_LINK    = 8'h0C;
  localparam logic [7:0] ADR_STATION = 8'h10;
  localparam logic [7:0] ADR_FILT    = 8'h40;

  // link register field positions
  localparam int unsigned F_BAUD_LSB = 0;
  localparam int unsigned F_PAR_LSB  = 4;
  localparam int unsigned F_STOP_BIT = 8;
  localparam int unsigned F_GAP_LSB  = 16;

  // reset values and limits
  localparam dic_ms_t     FILT_MS_RST    = 16'h0032;
  localparam logic [15:0] INVERT_RST     = 16'h0000;
  localparam logic [3:0]  BAUD_RST       = 4'h5;
  localparam logic [3:0]  BAUD_MAX       = 4'hA;
  localparam dic_parity_t PAR_RST        = PAR_EVEN;
  localparam logic        STOP2_RST      = 1'b0;
  localparam logic [7:0]  GAP_M1_RST     = 8'h07;
  localparam logic [7:0]  GAP_M1_MIN     = 8'h07;
  localparam logic [7:0]  STATION_M1_RST = 8'h00;

  // clock cycles per bit for a baud index
  function automatic dic_bitcyc_t dic_bit_cyc(input logic [3:0] sel);
    int unsigned r;
    r = CLK_HZ / 19200;
    case (sel)
      4'h0: r = CLK_HZ / 600;
      4'h1: r = CLK_HZ / 1200;
      4'h2: r = CLK_HZ / 2400;
      4'h3: r = CLK_HZ / 4800;
      4'h4: r = CLK_HZ / 9600;
      4'h6: r = CLK_HZ / 28800;
      4'h7: r = CLK_HZ / 38400;
      4'h8: r = CLK_HZ / 57600;
      4'h9: r = CLK_HZ / 76800;
      4'hA: r = CLK_HZ / 115200;
      default: r = CLK_HZ / 19200;
    endcase
    return r[16:0];
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] dic_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return m;
  endfunction
endpackage

// ---- core/dic_filt_cell.sv ----
// dic_filt_cell: stability filter for one field input
// assumes din is synchronous to mclk and ms_tick is a one-cycle pulse per ms
`timescale 1ns/1ps
`default_nettype none
module dic_filt_cell (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // time base and setting
  input  wire logic             ms_tick,
  input  wire dic_pkg::dic_ms_t filt_ms,
  // input and filtered level
  input  wire logic             din,
  output logic                  level_q
);
  import dic_pkg::*;

  logic        samp_q;
  logic [16:0] cnt_q;
  logic        stable_w;
  logic        due_w;

  // strictly more ticks than the setting, so a partial first ms never counts
  assign stable_w = (din == samp_q);
  assign due_w    = stable_w && (samp_q != level_q) && (cnt_q > {1'b0, filt_ms}); // RL1

  // previous sample, to see every change
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      samp_q <= 1'b0;
    end else begin
      samp_q <= din;
    end
  end

  // ms counter: cleared by any change or when nothing is pending
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 17'h00000;
    end else if (!stable_w || (samp_q == level_q)) begin
      cnt_q <= 17'h00000; // RL12
    end else if (ms_tick && (cnt_q != 17'h1FFFF)) begin
      cnt_q <= cnt_q + 17'h00001; // RL3
    end
  end

  // accepted level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
    end else if (due_w) begin
      level_q <= samp_q; // RL1
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_change_restarts: assert property (!stable_w |=> cnt_q == 17'h00000) // RL12
    else $error("filter count not restarted by input change");
  a_level_after_time: assert property ($changed(level_q) |->
      $past(cnt_q) > {1'b0, $past(filt_ms)} && $past(din) == level_q) // RL1
    else $error("level changed before filter time");
endmodule
`default_nettype wire

// ---- core/dic_top.sv ----
// dic_top: sixteen input conditioner with wishbone registers and link settings
// assumes a classic wishbone master on mclk and field inputs synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module dic_top #(
  parameter int unsigned TICK_CYC_P = dic_pkg::TICK_CYC,
  parameter int unsigned N_IN_P     = dic_pkg::N_IN
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // field inputs, bit 0 is input_one, bit 1 is input_two
  input  wire logic [N_IN_P-1:0]     din,
  // reported states and indicators
  output logic [N_IN_P-1:0]          report_q,
  output logic [N_IN_P-1:0]          led_q,
  // serial link settings
  output var dic_pkg::dic_link_cfg_t link_cfg_q
);
  import dic_pkg::*;

  logic [15:0]       tick_cnt_q;
  logic              ms_tick_q;
  logic [N_IN_P-1:0] lvl_w;
  logic [N_IN_P-1:0] inv_q;
  dic_ms_t           fms_q [N_IN_P];
  logic              req_w;
  logic              wr_w;
  logic [31:0]       rd_d;
  logic [31:0]       link_rd_w;
  logic [31:0]       link_new_w;
  logic [31:0]       stat_new_w;
  logic [31:0]       inv_new_w;
  logic              fsel_w;
  logic [3:0]        fidx_w;

  // one request per transfer: ack is high for one cycle only
  assign req_w  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w   = req_w && wb_we_i;
  assign fsel_w = (wb_adr_i[7:6] == ADR_FILT[7:6]);
  assign fidx_w = wb_adr_i[5:2];

  // ms time base shared by all filters, a single counter saves area
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 16'h0000;
      ms_tick_q  <= 1'b0;
    end else if (tick_cnt_q == 16'(TICK_CYC_P - 1)) begin
      tick_cnt_q <= 16'h0000;
      ms_tick_q  <= 1'b1; // RL3
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      ms_tick_q  <= 1'b0;
    end
  end

  // one filter per input, each with its own time
  for (genvar i = 0; i < N_IN_P; i++) begin : g_cell
    dic_filt_cell u_cell (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .ms_tick (ms_tick_q),
      .filt_ms (fms_q[i]),
      .din     (din[i]),
      .level_q (lvl_w[i])
    );
  end

  // reported state takes inversion, indicators never do
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      report_q <= '0;
      led_q    <= '0;
    end else begin
      report_q <= lvl_w ^ inv_q; // RL4 RL5
      led_q    <= lvl_w; // RL6
    end
  end

  // inversion mask, one bit per input
  assign inv_new_w = dic_merge({16'h0000, 16'(inv_q)}, wb_dat_i, wb_sel_i);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      inv_q <= N_IN_P'(INVERT_RST);
    end else if (wr_w && wb_adr_i == ADR_INVERT) begin
      inv_q <= inv_new_w[N_IN_P-1:0]; // RL5
    end
  end

  // per-input filter times
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N_IN_P; i++) begin
        fms_q[i] <= FILT_MS_RST; // RL2
      end
    end else if (wr_w && fsel_w && (int'(fidx_w) < N_IN_P)) begin
      fms_q[fidx_w] <= 16'(dic_merge({16'h0000, fms_q[fidx_w]}, wb_dat_i, wb_sel_i)); // RL2
    end
  end

  // link settings as software reads them back
  always_comb begin
    link_rd_w = 32'h00000000;
    link_rd_w[F_BAUD_LSB +: 4] = link_cfg_q.baud_sel;
    link_rd_w[F_PAR_LSB +: 3]  = link_cfg_q.parity;
    link_rd_w[F_STOP_BIT]      = link_cfg_q.stop2;
    link_rd_w[F_GAP_LSB +: 8]  = link_cfg_q.gap_m1;
  end
  assign link_new_w = dic_merge(link_rd_w, wb_dat_i, wb_sel_i);
  assign stat_new_w = dic_merge({24'h000000, link_cfg_q.station_m1}, wb_dat_i, wb_sel_i);

  // link settings: illegal codes keep the old value, short gaps clamp to 8
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link_cfg_q.baud_sel   <= BAUD_RST; // RL7
      link_cfg_q.bit_cyc    <= dic_bit_cyc(BAUD_RST);
      link_cfg_q.parity     <= PAR_RST; // RL8
      link_cfg_q.stop2      <= STOP2_RST; // RL9
      link_cfg_q.gap_m1     <= GAP_M1_RST; // RL10
      link_cfg_q.station_m1 <= STATION_M1_RST; // RL11
    end else if (wr_w && wb_adr_i == ADR_LINK) begin
      if (link_new_w[F_BAUD_LSB +: 4] <= BAUD_MAX) begin
        link_cfg_q.baud_sel <= link_new_w[F_BAUD_LSB +: 4]; // RL7
        link_cfg_q.bit_cyc  <= dic_bit_cyc(link_new_w[F_BAUD_LSB +: 4]);
      end
      if (link_new_w[F_PAR_LSB +: 3] <= PAR_SPACE) begin
        link_cfg_q.parity <= dic_parity_t'(link_new_w[F_PAR_LSB +: 3]); // RL8
      end
      link_cfg_q.stop2 <= link_new_w[F_STOP_BIT]; // RL9
      if (link_new_w[F_GAP_LSB +: 8] < GAP_M1_MIN) begin
        link_cfg_q.gap_m1 <= GAP_M1_MIN; // RL10
      end else begin
        link_cfg_q.gap_m1 <= link_new_w[F_GAP_LSB +: 8]; // RL10
      end
    end else if (wr_w && wb_adr_i == ADR_STATION) begin
      link_cfg_q.station_m1 <= stat_new_w[7:0]; // RL11
    end
  end

  // read decode; unmapped words read zero and still answer
  always_comb begin
    rd_d = 32'h00000000;
    if (fsel_w) begin
      if (int'(fidx_w) < N_IN_P) begin
        rd_d[15:0] = fms_q[fidx_w];
      end
    end else begin
      case (wb_adr_i)
        ADR_STATE:   rd_d[N_IN_P-1:0] = report_q;
        ADR_LEVEL:   rd_d[N_IN_P-1:0] = led_q;
        ADR_INVERT:  rd_d[N_IN_P-1:0] = inv_q;
        ADR_LINK:    rd_d = link_rd_w;
        ADR_STATION: rd_d[7:0] = link_cfg_q.station_m1;
        default:     rd_d = 32'h00000000;
      endcase
    end
  end

  // answer one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req_w;
      if (req_w && !wb_we_i) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_wb_ack_pulse: assert property (s_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_ms_tick_gap: assert property (ms_tick_q |=> !ms_tick_q) // RL3
    else $error("ms tick wider than one cycle");
  a_report_inverted: assert property (report_q == ($past(lvl_w) ^ $past(inv_q))) // RL4
    else $error("reported state does not follow inversion");
  a_inv_opposite: assert property (($past(lvl_w[0]) == $past(lvl_w[1])
      && $past(inv_q[1:0]) == 2'b10) |-> report_q[0] != report_q[1]) // RL5
    else $error("inverted and plain inputs report alike");
  a_led_no_inv: assert property (led_q == $past(lvl_w)) // RL6
    else $error("indicator does not show filtered level");
  a_filt_reset: assert property (!$past(rst_b) |-> fms_q[0] == FILT_MS_RST
      && link_cfg_q.baud_sel == BAUD_RST) // RL2
    else $error("filter time or baud wrong after reset");
  a_baud_legal: assert property (link_cfg_q.baud_sel <= BAUD_MAX
      && link_cfg_q.bit_cyc == dic_bit_cyc(link_cfg_q.baud_sel)) // RL7
    else $error("baud setting illegal or divisor stale");
  a_parity_legal: assert property (link_cfg_q.parity <= PAR_SPACE) // RL8
    else $error("parity code illegal");
  a_gap_range: assert property (link_cfg_q.gap_m1 >= GAP_M1_MIN) // RL10
    else $error("packet gap below eight bit times");
endmodule
`default_nettype wire

// ---- verification/dic_contacts.sv ----
// dic_contacts: field contact model for the conditioner inputs
// assumes the bench sets want and chatter just after a rising mclk edge
`timescale 1ns/1ps
`default_nettype none
module dic_contacts (
  // clock
  input  wire logic        mclk,
  // wanted levels and bounce enables
  input  wire logic [15:0] want,
  input  wire logic [15:0] chatter,
  // contact levels seen by the block
  output logic [15:0]      din
);
  logic ph_q;

  // known levels before the first edge
  initial begin
    ph_q = 1'b0;
    din  = 16'h0000;
  end

  // a bouncing contact flips every cycle, the harshest case for the restart logic
  always @(posedge mclk) begin
    ph_q <= ~ph_q;
    din  <= want ^ (chatter & {16{ph_q}});
  end
endmodule
`default_nettype wire

// ---- verification/digital_input_conditioner_test.sv ----
// digital_input_conditioner_test: self-checking bench for dic_top
// assumes dic_pkg and the contact model are compiled first
`timescale 1ns/1ps
`default_nettype none
module digital_input_conditioner_test;
  import dic_pkg::*;
  logic          mclk, rst_b, cyc, stb, we, ack;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat, inv;
  logic [15:0]   want, chat, din, rep, led;
  dic_link_cfg_t cfg;
  int            miscompares, compares, n;
  logic [31:0]   exp_q[$];
  string         nm_q[$];
  int unsigned   rates[11] = '{600, 1200, 2400, 4800, 9600, 19200, 28800, 38400,
                               57600, 76800, 115200};

  // short tick so one ms is ten cycles
  dic_top #(.TICK_CYC_P(10), .N_IN_P(16)) uut (.mclk(mclk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .din(din), .report_q(rep),
    .led_q(led), .link_cfg_q(cfg));
  dic_contacts contacts (.mclk(mclk), .want(want), .chatter(chat), .din(din));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one classic cycle held up to the edge that samples ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (k == 20) begin
      miscompares++;
      end_of_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic wait_led(input int i, input logic v);
    n = 0;
    while (led[i] !== v && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 2000) begin
      miscompares++;
      end_of_test();
    end
  endtask

  function automatic logic [31:0] lk(input logic [3:0] b, input logic [2:0] p,
                                     input logic s, input logic [7:0] g);
    return {8'h00, g, 7'h00, s, 1'b0, p, b};
  endfunction

  // read data is compared at the edge that samples ack
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(nm_q.pop_front(), rdat, exp_q.pop_front());
    end
  end

  initial begin
    {rst_b, cyc, stb, we, adr, wdat, want, chat} = '0;
    sel = 4'hF;
    void'($urandom(79));
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    check("bit_cyc", 32'(cfg.bit_cyc), 32'd2604);
    rd(ADR_LINK, lk(4'h5, 3'h2, 1'b0, 8'h07), "link");
    rd(ADR_STATION, 32'h0, "station");
    for (int i = 0; i < 16; i++) begin
      rd(ADR_FILT + 8'(4 * i), 32'h32, "filter");
    end
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      wb(1'b1, ADR_LINK, lk(4'(i), 3'(i % 6), 1'(i % 2), 8'(i * 23)));
      check("baud", 32'(cfg.baud_sel), (i < 11) ? i : 10);
      check("bit_cyc", 32'(cfg.bit_cyc), 50_000_000 / rates[(i < 11) ? i : 10]);
      check("parity", 32'(cfg.parity), (i % 6 < 5) ? i % 6 : 4);
      check("stop2", 32'(cfg.stop2), i % 2);
      check("gap", 32'(cfg.gap_m1), (i * 23 < 7) ? 7 : i * 23);
    end
    // only lane 0 enabled: stop and gap bytes in the data must not land
    sel <= 4'h1;
    wb(1'b1, ADR_LINK, 32'hFFFF_0003);
    sel <= 4'hF;
    check("lane baud", 32'(cfg.baud_sel), 32'h3);
    check("lane stop2", 32'(cfg.stop2), 32'h1);
    check("lane gap", 32'(cfg.gap_m1), 32'd253);
    for (int s = 0; s < 256; s += 85) begin
      wb(1'b1, ADR_STATION, 32'(s));
      rd(ADR_STATION, 32'(s), "station");
    end
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped");
    $display("test link settings done");
    wb(1'b1, ADR_FILT, 32'd3);
    want <= 16'h0001;
    chat <= 16'h0001;
    repeat (60) @(posedge mclk);
    check("bounce", 32'(led[0]), 32'h0);
    chat <= 16'h0000;
    wait_led(0, 1'b1);
    check("filter time", 32'(n >= 30 && n <= 48), 32'h1);
    $display("test filter timing done");
    wb(1'b1, ADR_INVERT, 32'h2);
    want <= 16'h0003;
    wait_led(1, 1'b1);
    check("report", 32'(rep), 32'h1);
    rd(ADR_LEVEL, 32'h3, "level");
    want <= 16'h0000;
    wait_led(1, 1'b0);
    rd(ADR_STATE, 32'h2, "state");
    $display("test inversion done");
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 16; i++) begin
        wb(1'b1, ADR_FILT + 8'(4 * i), 32'(1 + $urandom % 4));
      end
      inv = {16'h0, 16'($urandom)};
      wb(1'b1, ADR_INVERT, inv);
      want <= 16'($urandom);
      repeat (80) @(posedge mclk);
      rd(ADR_LEVEL, {16'h0, want}, "level");
      rd(ADR_STATE, {16'h0, want} ^ inv, "state");
    end
    $display("test random inputs done");
    end_of_test();
  end
endmodule
`default_nettype wire
